// ===== shared/core_ctrl_regs.vh
// Purpose: offsets, fields, reset values and counts of the core control block
// Assumes: avalon byte addresses, one 32-bit word per register
// Notes: included by both design files
`ifndef CORE_CTRL_REGS_VH
`define CORE_CTRL_REGS_VH
// ==========================================================
// register offsets
`define OFS_CORE_CTRL 8'h00
`define OFS_RAM_CFG 8'h04
`define OFS_POWER 8'h08
`define OFS_SL_BASE 8'h10
`define SL_PAIR_STEP 8'h08
`define SL_DATA_OFS 8'h04
// ==========================================================
// audio_core_control fields
`define B_SLEW_DONE 13
`define B_ZERO_TGT 12
`define B_LATCH_SRC 10
`define B_RUN 9
`define B_MULT_ZERO 8
`define B_MEM_CLR 7
`define B_IN_ZERO 6
`define B_SL_TGT 5
`define B_SL_PAR 4
`define F_SYNC_HI 3
`define F_SYNC_LO 2
`define F_LEN_HI 1
`define F_LEN_LO 0
`define CTRL_RST 16'h0000
`define CTRL_WMASK 16'h17ff
// ==========================================================
// codes and counts
`define SYNC_DIV2 2'h1
`define LEN_1280 2'h1
`define LEN_640 2'h2
`define PLEN_48K 12'ha00
`define PLEN_96K 12'h500
`define PLEN_192K 12'h280
`define RAM_CFG_UNIT 13'h0200
`define RAM_CFG_RST 4'hc
`define RAM_WORDS 13'h1800
`define SL_PAIRS 5
`endif

// ===== verilog/modulo_addr.v
// Purpose: maps core data addresses onto data memory with a frame offset
// Assumes: one frame pulse per audio frame
// Notes: region size of zero makes the whole memory direct
`timescale 1ns/100ps
`default_nettype none
`include "core_ctrl_regs.vh"
module modulo_addr
#(
  parameter AW = 13
)
(
  input wire mclk,
  input wire rst,
  input wire frame_pulse,
  input wire [3:0] ram_cfg,
  input wire [AW-1:0] core_addr,
  output reg [AW-1:0] phys_addr,
  output wire [AW-1:0] offset
);
  reg [AW-1:0] offs_r;
  wire [AW-1:0] region;
  wire [AW:0] sum;
  assign region = `RAM_CFG_UNIT * {{(AW-4){1'b0}}, ram_cfg};
  assign offset = offs_r;
  assign sum = {1'b0, core_addr} + {1'b0, offs_r};
  // ==========================================================
  // offset counter
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      offs_r <= {AW{1'b0}};
    else if (region == {AW{1'b0}})
      offs_r <= {AW{1'b0}};
    // a shrunk region must not leave the offset outside it
    else if (offs_r >= region)
      offs_r <= {AW{1'b0}};
    else if (frame_pulse)
    begin
      if (offs_r + 1'b1 >= region)
        offs_r <= {AW{1'b0}};
      else
        offs_r <= offs_r + 1'b1;
    end
  end
  // ==========================================================
  // address mapping
  always @*
  begin
    if (core_addr >= region)
      phys_addr = core_addr;
    else if (sum >= {1'b0, region})
      phys_addr = sum[AW-1:0] - region;
    else
      phys_addr = sum[AW-1:0];
  end
endmodule
`default_nettype wire

// ===== verilog/core_ctrl.v
// Purpose: audio core control register, safeload, memory clear, frame sync
// Assumes: all core and pin inputs synchronous to mclk
// Notes: avalon slave answers on the second edge of every request
//
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "core_ctrl_regs.vh"
// Behaviour
// - slew-mute-done flag sets when mute finished, read-only, cleared by reading
// - zero-target control makes target RAM read as zero
// - default output latch at end of each program pass
// - latch-source control times output latch from output frame clock
// - run/clear at zero holds accumulators and serial outputs at zero
// - multiplier-zero control forces multiplier input to zero
// - memory-clear zeroes all data memory, then self-clears
// - input-zero control forces serial inputs to zero
// - target-safeload trigger loads target RAM, self-clears when done
// - parameter-safeload trigger loads parameter RAM, self-clears when done
// - only safeload pairs written since last safeload are transferred
// - safeload address zero is first location of targeted RAM
// - sequencer synchronised to input frame clock edge by default
// - sync field 01 synchronises sequencer to half input frame rate
// - program length 2560, 1280 with 01, 640 with 10
// - power-up controls reset to zero, each block powered by its bit
// - modulo addresses add a frame-advanced offset counter
// - modulo region is 512 times config value, wrapping at its edge
// - addresses above the modulo region are accessed directly
// - default config puts whole data RAM under modulo addressing
// - safeload completes within one input frame period of trigger; here it ends five cycles after the next input frame edge
module core_ctrl
#(
  parameter AW = 13,
  parameter SL_AW = 10,
  parameter SL_DW = 32,
  parameter PW = 16
)
(
  input wire mclk,
  input wire rst,
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output wire waitrequest,
  input wire frame_clk_in,
  input wire frame_clk_out,
  input wire [11:0] pc,
  input wire slew_all_zero,
  input wire [AW-1:0] core_addr,
  output wire [AW-1:0] dmem_addr,
  output reg dmem_clr_we,
  output reg [AW-1:0] dmem_clr_addr,
  output reg [11:0] prog_len,
  output reg seq_sync,
  output reg out_latch,
  output wire hold_clear,
  output wire mult_zero,
  output wire input_zero,
  output wire target_zero,
  output reg sl_we,
  output reg sl_to_target,
  output reg [SL_AW-1:0] sl_addr,
  output reg [SL_DW-1:0] sl_data,
  output wire [PW-1:0] power_up
);
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_RUN = 3'b100;

  reg [15:0] ctrl_r;
  reg [3:0] ram_cfg_r;
  reg [PW-1:0] power_r;
  reg [SL_AW-1:0] sl_addr_r [0:`SL_PAIRS-1];
  reg [SL_DW-1:0] sl_data_r [0:`SL_PAIRS-1];
  reg [`SL_PAIRS-1:0] sl_pend_r;
  reg [`SL_PAIRS-1:0] sl_pend_nxt;
  reg ack_r;
  reg fin_d_r;
  reg fout_d_r;
  reg div_r;
  reg slew_done_r;
  reg zero_seen_r;
  reg [2:0] sl_st_r;
  reg [2:0] sl_idx_r;
  reg sl_tgt_r;
  reg clr_busy_r;
  reg [31:0] rd_nxt;
  wire acc;
  wire wr_acc;
  wire rd_acc;
  wire fin_rise;
  wire fout_rise;
  wire end_of_pass;
  wire frame_pulse;
  wire sl_fin;
  wire clr_fin;
  wire done_set;
  integer i;
  integer j;
  integer k;

  // ==========================================================
  // helpers
  function [11:0] len_of;
    input [1:0] code;
    begin
      case (code)
        `LEN_1280: len_of = `PLEN_96K;
        `LEN_640: len_of = `PLEN_192K;
        default: len_of = `PLEN_48K;
      endcase
    end
  endfunction

  function is_sl_addr;
    input [7:0] a;
    input integer n;
    begin
      is_sl_addr = (a == `OFS_SL_BASE + `SL_PAIR_STEP * n[7:0]);
    end
  endfunction

  function is_sl_data;
    input [7:0] a;
    input integer n;
    begin
      is_sl_data = (a == `OFS_SL_BASE + `SL_PAIR_STEP * n[7:0] + `SL_DATA_OFS);
    end
  endfunction

  // ==========================================================
  // avalon slave: waitrequest drops one cycle after the request rises
  assign waitrequest = ~ack_r;
  assign acc = (read | write) & ack_r;
  assign wr_acc = write & ack_r;
  assign rd_acc = read & ack_r;

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      ack_r <= 1'b0;
    else
      ack_r <= (read | write) & ~ack_r;
  end

  always @*
  begin
    rd_nxt = 32'h00000000;
    case (address)
      `OFS_CORE_CTRL: rd_nxt = {16'h0000, ctrl_r[15:14], slew_done_r, ctrl_r[12:0]};
      `OFS_RAM_CFG: rd_nxt = {28'h0000000, ram_cfg_r};
      `OFS_POWER: rd_nxt[PW-1:0] = power_r;
      default:
      begin
        for (i = 0; i < `SL_PAIRS; i = i + 1)
        begin
          if (is_sl_addr(address, i))
            rd_nxt[SL_AW-1:0] = sl_addr_r[i];
          if (is_sl_data(address, i))
            rd_nxt[SL_DW-1:0] = sl_data_r[i];
        end
      end
    endcase
  end

  // data loaded while waitrequest is high, so it stands at the taking edge
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      readdata <= 32'h00000000;
    else if (read & ~ack_r)
      readdata <= rd_nxt;
  end

  // ==========================================================
  // control register; a software set of a trigger beats the hardware clear
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      ctrl_r <= `CTRL_RST;
    else if (wr_acc && address == `OFS_CORE_CTRL)
      ctrl_r <= writedata[15:0] & `CTRL_WMASK;
    else
    begin
      if (clr_fin)
        ctrl_r[`B_MEM_CLR] <= 1'b0;
      if (sl_fin && sl_tgt_r)
        ctrl_r[`B_SL_TGT] <= 1'b0;
      if (sl_fin && !sl_tgt_r)
        ctrl_r[`B_SL_PAR] <= 1'b0;
    end
  end

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ram_cfg_r <= `RAM_CFG_RST;
      power_r <= {PW{1'b0}};
    end
    else if (wr_acc)
    begin
      if (address == `OFS_RAM_CFG)
        ram_cfg_r <= (writedata[3:0] > `RAM_CFG_RST) ? `RAM_CFG_RST : writedata[3:0];
      if (address == `OFS_POWER)
        power_r <= writedata[PW-1:0];
    end
  end

  assign power_up = power_r;
  assign hold_clear = ~ctrl_r[`B_RUN];
  assign mult_zero = ctrl_r[`B_MULT_ZERO];
  assign input_zero = ctrl_r[`B_IN_ZERO];
  assign target_zero = ctrl_r[`B_ZERO_TGT];

  // ==========================================================
  // slew mute done: needs a fresh all-zero state while targets are zeroed
  assign done_set = target_zero & slew_all_zero & ~zero_seen_r;

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      slew_done_r <= 1'b0;
      zero_seen_r <= 1'b0;
    end
    else
    begin
      zero_seen_r <= target_zero & slew_all_zero;
      if (done_set)
        slew_done_r <= 1'b1;
      else if (rd_acc && address == `OFS_CORE_CTRL)
        slew_done_r <= 1'b0;
    end
  end

  // ==========================================================
  // frame timing
  assign fin_rise = frame_clk_in & ~fin_d_r;
  assign fout_rise = frame_clk_out & ~fout_d_r;
  assign end_of_pass = (pc == prog_len - 12'h001);
  assign frame_pulse = fin_rise &
    ((ctrl_r[`F_SYNC_HI:`F_SYNC_LO] != `SYNC_DIV2) | div_r);

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      fin_d_r <= 1'b0;
      fout_d_r <= 1'b0;
      div_r <= 1'b0;
      seq_sync <= 1'b0;
      out_latch <= 1'b0;
      prog_len <= `PLEN_48K;
    end
    else
    begin
      fin_d_r <= frame_clk_in;
      fout_d_r <= frame_clk_out;
      if (fin_rise)
        div_r <= ~div_r;
      seq_sync <= frame_pulse;
      prog_len <= len_of(ctrl_r[`F_LEN_HI:`F_LEN_LO]);
      if (ctrl_r[`B_LATCH_SRC])
        out_latch <= fout_rise;
      else
        out_latch <= end_of_pass;
    end
  end

  // ==========================================================
  // data memory clear, one word per cycle
  assign clr_fin = clr_busy_r && dmem_clr_addr == `RAM_WORDS - 13'h0001;

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      clr_busy_r <= 1'b0;
      dmem_clr_we <= 1'b0;
      dmem_clr_addr <= {AW{1'b0}};
    end
    else if (clr_busy_r)
    begin
      if (clr_fin)
      begin
        clr_busy_r <= 1'b0;
        dmem_clr_we <= 1'b0;
      end
      else
        dmem_clr_addr <= dmem_clr_addr + 1'b1;
    end
    else if (ctrl_r[`B_MEM_CLR])
    begin
      clr_busy_r <= 1'b1;
      dmem_clr_we <= 1'b1;
      dmem_clr_addr <= {AW{1'b0}};
    end
  end

  // ==========================================================
  // safeload registers and engine
  // transfer starts at the next frame edge, long before the following one
  assign sl_fin = (sl_st_r == ST_RUN) && (sl_idx_r == `SL_PAIRS - 1);

  always @*
  begin
    sl_pend_nxt = sl_pend_r;
    if (sl_st_r == ST_RUN && sl_idx_r < `SL_PAIRS)
      sl_pend_nxt[sl_idx_r] = 1'b0;
    for (j = 0; j < `SL_PAIRS; j = j + 1)
      if (wr_acc && (is_sl_addr(address, j) || is_sl_data(address, j)))
        sl_pend_nxt[j] = 1'b1;
  end

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sl_pend_r <= {`SL_PAIRS{1'b0}};
      for (k = 0; k < `SL_PAIRS; k = k + 1)
      begin
        sl_addr_r[k] <= {SL_AW{1'b0}};
        sl_data_r[k] <= {SL_DW{1'b0}};
      end
    end
    else
    begin
      sl_pend_r <= sl_pend_nxt;
      for (k = 0; k < `SL_PAIRS; k = k + 1)
      begin
        if (wr_acc && is_sl_addr(address, k))
          sl_addr_r[k] <= writedata[SL_AW-1:0];
        if (wr_acc && is_sl_data(address, k))
          sl_data_r[k] <= writedata[SL_DW-1:0];
      end
    end
  end

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sl_st_r <= ST_IDLE;
      sl_idx_r <= 3'h0;
      sl_tgt_r <= 1'b0;
      sl_we <= 1'b0;
      sl_to_target <= 1'b0;
      sl_addr <= {SL_AW{1'b0}};
      sl_data <= {SL_DW{1'b0}};
    end
    else
    begin
      sl_we <= 1'b0;
      case (sl_st_r)
        ST_IDLE:
        begin
          if (ctrl_r[`B_SL_PAR] | ctrl_r[`B_SL_TGT])
          begin
            sl_tgt_r <= ~ctrl_r[`B_SL_PAR];
            sl_st_r <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          sl_idx_r <= 3'h0;
          // raw frame edge: divided sync must not push it past one period
          if (fin_rise)
            sl_st_r <= ST_RUN;
        end
        ST_RUN:
        begin
          if (sl_pend_r[sl_idx_r])
          begin
            sl_we <= 1'b1;
            sl_to_target <= sl_tgt_r;
            sl_addr <= sl_addr_r[sl_idx_r];
            sl_data <= sl_data_r[sl_idx_r];
          end
          if (sl_fin)
            sl_st_r <= ST_IDLE;
          else
            sl_idx_r <= sl_idx_r + 3'h1;
        end
        default: sl_st_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // modulo addressing
  modulo_addr #(.AW(AW)) u_mod
  (
    .mclk(mclk),
    .rst(rst),
    .frame_pulse(frame_pulse),
    .ram_cfg(ram_cfg_r),
    .core_addr(core_addr),
    .phys_addr(dmem_addr),
    .offset()
  );
endmodule
`default_nettype wire

// ===== verification/core_ctrl_asserts.sv
// Purpose: port-level properties of the core control block
// Assumes: single mclk domain, asynchronous active-high reset
// Notes: control fields are judged against a shadow of accepted writes
`timescale 1ns/100ps
`default_nettype none
`include "core_ctrl_regs.vh"
module core_ctrl_asserts
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic waitrequest,
  input wire logic frame_clk_in,
  input wire logic frame_clk_out,
  input wire logic [11:0] pc,
  input wire logic dmem_clr_we,
  input wire logic [12:0] dmem_clr_addr,
  input wire logic [11:0] prog_len,
  input wire logic seq_sync,
  input wire logic out_latch,
  input wire logic hold_clear,
  input wire logic mult_zero,
  input wire logic input_zero,
  input wire logic target_zero
);
  logic [15:0] cw_r;
  logic [1:0] age_r;
  wire take = write && !waitrequest && address == `OFS_CORE_CTRL;
  // shadow is trusted only once registered outputs had time to follow
  wire ok = age_r == 2'h3;
  wire [11:0] len_exp = (cw_r[1:0] == `LEN_1280) ? `PLEN_96K : (cw_r[1:0] == `LEN_640) ? `PLEN_192K : `PLEN_48K;
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cw_r <= `CTRL_RST;
      age_r <= 2'h3;
    end
    else if (take)
    begin
      cw_r <= writedata[15:0];
      age_r <= 2'h0;
    end
    else if (age_r != 2'h3)
      age_r <= age_r + 2'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================================
  // control outputs
  a_run_hold: assert property (ok |-> hold_clear == !cw_r[`B_RUN])
    else $error("hold_clear does not follow run control");
  a_mult_zero: assert property (ok |-> mult_zero == cw_r[`B_MULT_ZERO])
    else $error("mult_zero does not follow its control");
  a_in_zero: assert property (ok |-> input_zero == cw_r[`B_IN_ZERO])
    else $error("input_zero does not follow its control");
  a_tgt_zero: assert property (ok |-> target_zero == cw_r[`B_ZERO_TGT])
    else $error("target_zero does not follow its control");
  a_len_code: assert property (ok |-> prog_len == len_exp)
    else $error("prog_len does not match length code");
  // ==========================================================
  // timing pulses
  a_end_latch: assert property (ok && !cw_r[`B_LATCH_SRC] && pc == prog_len - 12'h001 |=> out_latch)
    else $error("no output latch at end of pass");
  a_frame_latch: assert property (ok && cw_r[`B_LATCH_SRC] && $rose(frame_clk_out) |-> ##[1:2] out_latch)
    else $error("no output latch after output frame edge");
  a_sync_edge: assert property (ok && cw_r[3:2] == 2'h0 && $rose(frame_clk_in) |-> ##[1:2] seq_sync)
    else $error("no sequencer sync after input frame edge");
  // ==========================================================
  // memory clear sweep
  a_clr_start: assert property ($rose(dmem_clr_we) |-> dmem_clr_addr == 13'h0000)
    else $error("memory clear does not start at zero");
  a_clr_step: assert property (dmem_clr_we && dmem_clr_addr != `RAM_WORDS - 13'h0001
    |=> dmem_clr_we && dmem_clr_addr == $past(dmem_clr_addr) + 13'h0001)
    else $error("memory clear skipped or stopped early");
  a_clr_end: assert property ($fell(dmem_clr_we) |-> $past(dmem_clr_addr) == `RAM_WORDS - 13'h0001)
    else $error("memory clear ended at wrong address");
endmodule
bind core_ctrl core_ctrl_asserts u_chk (.mclk(mclk), .rst(rst), .address(address), .write(write),
  .writedata(writedata), .waitrequest(waitrequest), .frame_clk_in(frame_clk_in), .frame_clk_out(frame_clk_out),
  .pc(pc), .dmem_clr_we(dmem_clr_we), .dmem_clr_addr(dmem_clr_addr), .prog_len(prog_len), .seq_sync(seq_sync),
  .out_latch(out_latch), .hold_clear(hold_clear), .mult_zero(mult_zero), .input_zero(input_zero),
  .target_zero(target_zero));
`default_nettype wire

// ===== verification/dsp_core_control_and_modulo_ram_tb.sv
// Purpose: register-level tests of the core control block
// Assumes: avalon master with bounded waits, frame clocks 16 cycles long
// Notes: expectations derive from the register header constants
`timescale 1ns/100ps
`default_nettype none
`include "core_ctrl_regs.vh"
module dsp_core_control_and_modulo_ram_tb;
  logic mclk, rst, read, write, frame_clk_in, frame_clk_out, slew_all_zero;
  logic [7:0] address;
  logic [31:0] writedata, rdv;
  logic [11:0] pc;
  logic [12:0] core_addr, a0, a1;
  logic [42:0] q[$];
  logic [11:0] lens[4] = '{`PLEN_48K, `PLEN_96K, `PLEN_192K, `PLEN_48K};
  wire [31:0] readdata, sl_data;
  wire waitrequest, dmem_clr_we, seq_sync, out_latch, hold_clear, mult_zero, input_zero, target_zero, sl_we, sl_to_target;
  wire [12:0] dmem_addr, dmem_clr_addr;
  wire [11:0] prog_len;
  wire [9:0] sl_addr;
  wire [15:0] power_up;
  int bad_count, total_checks, ks, kl, i, c;
  core_ctrl DUT (.mclk(mclk), .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .frame_clk_in(frame_clk_in), .frame_clk_out(frame_clk_out),
    .pc(pc), .slew_all_zero(slew_all_zero), .core_addr(core_addr), .dmem_addr(dmem_addr),
    .dmem_clr_we(dmem_clr_we), .dmem_clr_addr(dmem_clr_addr), .prog_len(prog_len), .seq_sync(seq_sync),
    .out_latch(out_latch), .hold_clear(hold_clear), .mult_zero(mult_zero), .input_zero(input_zero),
    .target_zero(target_zero), .sl_we(sl_we), .sl_to_target(sl_to_target), .sl_addr(sl_addr),
    .sl_data(sl_data), .power_up(power_up));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ==========================================================
  // tasks
  task final_report;
  begin
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
  begin
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  // ends at a falling edge so register effects have landed
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
  begin
    @(posedge mclk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 40);
    if (waitrequest !== 1'b0)
    begin
      bad_count++;
      final_report;
    end
    // pre-edge values: this is the accepting edge
    rdv = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(negedge mclk);
  end
  endtask
  task frames(input int n);
  begin
    ks = 0;
    kl = 0;
    q.delete();
    for (c = 0; c < 16 * n; c++)
    begin
      @(posedge mclk);
      if (c % 8 == 0)
      begin
        frame_clk_in <= ~frame_clk_in;
        frame_clk_out <= ~frame_clk_out;
      end
      @(negedge mclk);
      ks += (seq_sync === 1'b1);
      kl += (out_latch === 1'b1);
      if (sl_we === 1'b1)
        q.push_back({sl_to_target, sl_addr, sl_data});
    end
  end
  endtask
  task endpass(input logic [11:0] len);
  begin
    kl = 0;
    @(posedge mclk);
    pc <= len - 12'h001;
    @(posedge mclk);
    pc <= 12'h000;
    repeat (3)
    begin
      @(negedge mclk);
      kl += (out_latch === 1'b1);
    end
  end
  endtask
  task probe(input logic [12:0] a, output logic [12:0] r);
  begin
    @(posedge mclk);
    core_addr <= a;
    @(negedge mclk);
    r = dmem_addr;
  end
  endtask
  // ==========================================================
  // sequence
  initial
  begin
    rst = 1'b1;
    {read, write, frame_clk_in, frame_clk_out, slew_all_zero} = 5'h00;
    address = 8'h00;
    writedata = 32'h00000000;
    pc = 12'h000;
    core_addr = 13'h0064;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk("reset flags", 4'h4, {target_zero, hold_clear, mult_zero, input_zero});
    chk("reset map", 13'h0064, dmem_addr);
    bus(0, `OFS_CORE_CTRL, 0);
    chk("ctrl reset", `CTRL_RST, rdv);
    bus(0, `OFS_RAM_CFG, 0);
    chk("ram_cfg reset", `RAM_CFG_RST, rdv);
    bus(0, `OFS_POWER, 0);
    chk("power reset", 32'h0, {rdv[31:16], power_up});
    bus(1, `OFS_POWER, 32'h0000a5a5);
    chk("power_up", 16'ha5a5, power_up);
    bus(0, 8'h40, 0);
    chk("unmapped", 32'h0, rdv);
    for (i = 0; i < 4; i++)
    begin
      bus(1, `OFS_CORE_CTRL, i);
      @(negedge mclk);
      chk("prog_len", lens[i], prog_len);
    end
    bus(1, `OFS_CORE_CTRL, 32'h00003340);
    chk("set flags", 4'hb, {target_zero, hold_clear, mult_zero, input_zero});
    bus(0, `OFS_CORE_CTRL, 0);
    chk("ctrl readback", 32'h00001340, rdv);
    @(posedge mclk);
    slew_all_zero <= 1'b1;
    bus(0, `OFS_CORE_CTRL, 0);
    chk("slew done", 1'b1, rdv[`B_SLEW_DONE]);
    bus(0, `OFS_CORE_CTRL, 0);
    chk("slew done cleared", 1'b0, rdv[`B_SLEW_DONE]);
    bus(1, `OFS_CORE_CTRL, 32'h00000000);
    chk("clear flags", 4'h4, {target_zero, hold_clear, mult_zero, input_zero});
    bus(0, `OFS_CORE_CTRL, 0);
    chk("no done without zero target", 1'b0, rdv[`B_SLEW_DONE]);
    @(posedge mclk);
    slew_all_zero <= 1'b0;
    bus(1, `OFS_CORE_CTRL, 32'h00000202);
    endpass(`PLEN_192K);
    chk("end latch", 1, kl);
    frames(2);
    chk("sync count", 2, ks);
    bus(1, `OFS_CORE_CTRL, 32'h00000602);
    endpass(`PLEN_192K);
    chk("no end latch", 0, kl);
    frames(2);
    chk("frame latch", 2, kl);
    bus(1, `OFS_CORE_CTRL, 32'h00000206);
    frames(4);
    chk("half sync", 2, ks);
    bus(1, `OFS_SL_BASE, 32'h0);
    bus(1, `OFS_SL_BASE + `SL_DATA_OFS, 32'h12345678);
    bus(1, `OFS_SL_BASE + 3 * `SL_PAIR_STEP, 32'h5);
    bus(1, `OFS_SL_BASE + 3 * `SL_PAIR_STEP + `SL_DATA_OFS, 32'hcafe0001);
    bus(1, `OFS_CORE_CTRL, 32'h00000210);
    frames(1);
    chk("param count", 2, q.size());
    chk("param first", {1'b0, 10'h000}, q[0][42:32]);
    chk("param first data", 32'h12345678, q[0][31:0]);
    chk("param second", {1'b0, 10'h005}, q[1][42:32]);
    bus(0, `OFS_CORE_CTRL, 0);
    chk("param trigger", 1'b0, rdv[`B_SL_PAR]);
    bus(1, `OFS_CORE_CTRL, 32'h00000220);
    frames(1);
    chk("nothing pending", 0, q.size());
    bus(0, `OFS_CORE_CTRL, 0);
    chk("target trigger", 1'b0, rdv[`B_SL_TGT]);
    bus(1, `OFS_SL_BASE + 4 * `SL_PAIR_STEP + `SL_DATA_OFS, 32'h00000077);
    bus(1, `OFS_CORE_CTRL, 32'h00000220);
    frames(1);
    chk("target count", 1, q.size());
    chk("target side", 1'b1, q[0][42]);
    chk("target word", 32'h00000077, q[0][31:0]);
    bus(1, `OFS_CORE_CTRL, 32'h00000280);
    c = 0;
    repeat (6400)
    begin
      @(negedge mclk);
      c += (dmem_clr_we === 1'b1);
    end
    chk("clear words", 6144, c);
    bus(0, `OFS_CORE_CTRL, 0);
    chk("clear bit", 1'b0, rdv[`B_MEM_CLR]);
    bus(1, `OFS_RAM_CFG, 32'h1);
    probe(13'h0000, a0);
    probe(13'h01ff, a1);
    chk("in region", 1'b1, a0 < 13'h0200);
    chk("wrap", (a0 + 13'h01ff) & 13'h01ff, a1);
    probe(13'h02bc, a1);
    chk("direct", 13'h02bc, a1);
    frames(1);
    probe(13'h0000, a1);
    chk("offset step", (a0 + 13'h0001) & 13'h01ff, a1);
    bus(1, `OFS_RAM_CFG, 32'hf);
    bus(0, `OFS_RAM_CFG, 0);
    chk("cfg clamp", `RAM_CFG_RST, rdv);
    final_report;
  end
endmodule
`default_nettype wire
